// ===== core/aasr_pkg.sv
// constants for the auto-negotiation ability and status register group
package aasr_pkg;

  // ----------------------------------------------------------------
  // register geometry
  // ----------------------------------------------------------------
  localparam int           REG_W          = 16;
  localparam int           SEL_W          = 5;
  localparam int           BUS_W          = 32;
  localparam int           IDX_W          = 6;
  localparam int           IDX_LSB        = 2;    // byte address = 4 * index
  localparam int           STRAP_STAGES   = 3;

  // register indices; byte address is index * 4
  localparam logic [IDX_W-1:0] IDX_ADVERT  = 6'h04;
  localparam logic [IDX_W-1:0] IDX_PARTNER = 6'h05;
  localparam logic [IDX_W-1:0] IDX_EXPAND  = 6'h06;

  // ----------------------------------------------------------------
  // local_ability_advert fields
  // ----------------------------------------------------------------
  localparam int           ADV_TEN_HALF   = 5;
  localparam int           ADV_SEL_MSB    = 4;
  localparam int           ADV_SEL_LSB    = 0;
  localparam logic [SEL_W-1:0] ADV_SEL_RST = 5'h01;

  // ----------------------------------------------------------------
  // partner_base_page_ability fields
  // ----------------------------------------------------------------
  localparam int           LP_MORE_PAGES  = 15;
  localparam int           LP_ACK         = 14;
  localparam int           LP_REMOTE_FLT  = 13;
  localparam int           LP_RESERVED    = 12;
  localparam int           LP_ASYM_FLOW   = 11;
  localparam int           LP_SYM_PAUSE   = 10;
  localparam int           LP_TECH_MSB    = 9;
  localparam int           LP_TECH_LSB    = 5;
  localparam int           LP_SEL_MSB     = 4;
  localparam int           LP_SEL_LSB     = 0;
  localparam logic [REG_W-1:0] LP_RST      = 16'h0000;
  // bits captured from a received page; ack and reserved are not stored
  localparam logic [REG_W-1:0] LP_LOAD_MASK = 16'hAFFF;

  // ----------------------------------------------------------------
  // negotiation_expansion_status fields
  // ----------------------------------------------------------------
  localparam int           EXP_LOC_REPORTED = 6;
  localparam int           EXP_LOC_SELECT   = 5;
  localparam int           EXP_PD_FAULT     = 4;
  localparam int           EXP_PARTNER_EXTRA_PAGE_CAPABLE   = 3;
  localparam int           EXP_LOCAL_NP     = 2;
  localparam int           EXP_PAGE_RX      = 1;
  localparam int           EXP_PARTNER_NEGOTIATION_CAPABLE   = 0;
  localparam logic         EXP_LOC_SEL_RST  = 1'b1;

endpackage

// ===== core/aasr_regs.sv
// auto-negotiation advertisement, partner ability and expansion registers
// ----------------------------------------------------------------
// ----------------------------------------------------------------
`timescale 1ns/1ps

module aasr_regs
  import aasr_pkg::*;
#(
  parameter int ADDR_W = 8
) (
  input  wire logic              clk_i,
  input  wire logic              rst_i,
  // wishbone classic slave
  input  wire logic              wb_cyc_i,
  input  wire logic              wb_stb_i,
  input  wire logic              wb_we_i,
  input  wire logic [ADDR_W-1:0] wb_adr_i,
  input  wire logic [3:0]        wb_sel_i,
  input  wire logic [BUS_W-1:0]  wb_dat_i,
  output logic      [BUS_W-1:0]  wb_dat_o,
  output logic                   wb_ack_o,
  // strap pin for ten half advertisement
  input  wire logic              strap_ten_half_i,
  // negotiation engine, same clock
  input  wire logic              an_page_valid_i,
  input  wire logic [REG_W-1:0]  an_page_word_i,
  input  wire logic              an_next_page_valid_i,
  input  wire logic [REG_W-1:0]  an_next_page_word_i,
  input  wire logic              an_partner_ack_i,
  input  wire logic              an_page_loc_select_i,
  input  wire logic              an_parallel_fault_i,
  input  wire logic              an_partner_capable_i,
  // advertisement and page received flag towards the negotiation engine
  output logic                   local_ten_half_adv_o,
  output logic      [SEL_W-1:0]  local_selector_o,
  output logic                   page_received_o
);

  // ----------------------------------------------------------------
  // elaboration checks
  // ----------------------------------------------------------------
  if (ADDR_W < IDX_W + IDX_LSB) begin : g_addr_chk
    $error("aasr_regs: ADDR_W too small for the register map");
  end

  // agreement of the last two stages needs one stage in front of them
  if (STRAP_STAGES < 3) begin : g_strap_chk
    $error("aasr_regs: strap synchroniser needs three stages");
  end

  if (BUS_W < REG_W) begin : g_bus_chk
    $error("aasr_regs: bus narrower than a register");
  end

  if (ADV_SEL_MSB - ADV_SEL_LSB + 1 != SEL_W) begin : g_adv_sel_chk
    $error("aasr_regs: advert selector field does not match SEL_W");
  end

  if (LP_SEL_MSB - LP_SEL_LSB + 1 != SEL_W) begin : g_lp_sel_chk
    $error("aasr_regs: partner selector field does not match SEL_W");
  end

  // ack and reserved bits never come from the page word
  if (LP_LOAD_MASK[LP_ACK] || LP_LOAD_MASK[LP_RESERVED]) begin : g_mask_chk
    $error("aasr_regs: page load mask covers ack or reserved");
  end

  // ----------------------------------------------------------------
  // strap synchroniser
  // ----------------------------------------------------------------
  logic [STRAP_STAGES-1:0] strap_sync_q;
  logic                    strap_stable;

  always_ff @(posedge clk_i) begin
    strap_sync_q <= {strap_sync_q[STRAP_STAGES-2:0], strap_ten_half_i};
  end

  // stage 0 is only read by stage 1; the last two must agree
  assign strap_stable = strap_sync_q[STRAP_STAGES-2] == strap_sync_q[STRAP_STAGES-1];

  // ----------------------------------------------------------------
  // bus decode
  // ----------------------------------------------------------------
  logic             req;
  logic             wr_en;
  logic             rd_en;
  logic [IDX_W-1:0] idx;
  logic             hit_advert;
  logic             hit_expand;
  logic             ack_q;

  // one answer per request; the cycle in which ack is high blocks a repeat
  assign req        = wb_cyc_i && wb_stb_i && !ack_q;
  assign wr_en      = req && wb_we_i;
  assign rd_en      = req && !wb_we_i;
  assign idx        = wb_adr_i[IDX_LSB +: IDX_W];
  assign hit_advert = idx == IDX_ADVERT;
  assign hit_expand = idx == IDX_EXPAND;

  // ----------------------------------------------------------------
  // local_ability_advert
  // ----------------------------------------------------------------
  logic             ten_half_q;
  logic [SEL_W-1:0] sel_q;

  // reset must be held four cycles so the strap has settled
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      if (strap_stable) begin
        ten_half_q <= strap_sync_q[STRAP_STAGES-1];
      end
    end else if (wr_en && hit_advert && wb_sel_i[0]) begin
      ten_half_q <= wb_dat_i[ADV_TEN_HALF];
    end
  end

  // a write updates sel_q at once and reaches local_selector_o one cycle later
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      sel_q <= ADV_SEL_RST;
    end else if (wr_en && hit_advert && wb_sel_i[0]) begin
      sel_q <= wb_dat_i[ADV_SEL_MSB:ADV_SEL_LSB];
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      local_ten_half_adv_o <= 1'b0;
      local_selector_o     <= ADV_SEL_RST;
    end else begin
      local_ten_half_adv_o <= ten_half_q;
      local_selector_o     <= sel_q;
    end
  end

  // ----------------------------------------------------------------
  // partner_base_page_ability
  // ----------------------------------------------------------------
  logic                               lp_load;
  logic [REG_W-1:0]                   lp_load_word;
  logic                               lp_more_q;
  logic                               lp_rflt_q;
  logic [LP_ASYM_FLOW-LP_SYM_PAUSE:0] lp_pause_q;
  logic [LP_TECH_MSB-LP_TECH_LSB:0]   lp_tech_q;
  logic [SEL_W-1:0]                   lp_sel_q;
  logic                               lp_ack_q;
  logic                               loc_sel_q;

  // base page wins over a next page in the same cycle; next pages
  // overwrite the base page only while the location bit points here
  always_comb begin
    lp_load      = 1'b0;
    lp_load_word = an_page_word_i & LP_LOAD_MASK;
    if (an_page_valid_i) begin
      lp_load      = 1'b1;
    end else if (an_next_page_valid_i && !loc_sel_q) begin
      lp_load      = 1'b1;
      lp_load_word = an_next_page_word_i & LP_LOAD_MASK;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      lp_more_q <= LP_RST[LP_MORE_PAGES];
    end else if (lp_load) begin
      lp_more_q <= lp_load_word[LP_MORE_PAGES];
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      lp_rflt_q <= LP_RST[LP_REMOTE_FLT];
    end else if (lp_load) begin
      lp_rflt_q <= lp_load_word[LP_REMOTE_FLT];
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      lp_pause_q <= LP_RST[LP_ASYM_FLOW:LP_SYM_PAUSE];
    end else if (lp_load) begin
      lp_pause_q <= lp_load_word[LP_ASYM_FLOW:LP_SYM_PAUSE];
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      lp_tech_q <= LP_RST[LP_TECH_MSB:LP_TECH_LSB];
    end else if (lp_load) begin
      lp_tech_q <= lp_load_word[LP_TECH_MSB:LP_TECH_LSB];
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      lp_sel_q <= LP_RST[LP_SEL_MSB:LP_SEL_LSB];
    end else if (lp_load) begin
      lp_sel_q <= lp_load_word[LP_SEL_MSB:LP_SEL_LSB];
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      lp_ack_q <= 1'b0;
    end else begin
      lp_ack_q <= an_partner_ack_i;
    end
  end

  // ----------------------------------------------------------------
  // negotiation_expansion_status
  // ----------------------------------------------------------------
  logic pd_fault_q;
  logic partner_extra_page_capable_q;
  logic page_rx_q;
  logic partner_negotiation_capable_q;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      loc_sel_q <= EXP_LOC_SEL_RST;
    end else begin
      loc_sel_q <= an_page_loc_select_i;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      pd_fault_q <= 1'b0;
    end else begin
      pd_fault_q <= an_parallel_fault_i;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      partner_extra_page_capable_q <= 1'b0;
    end else if (an_page_valid_i) begin
      partner_extra_page_capable_q <= an_page_word_i[LP_MORE_PAGES];
    end
  end

  // a page arriving in the clearing read cycle stays set
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      page_rx_q <= 1'b0;
    end else if (an_page_valid_i || an_next_page_valid_i) begin
      page_rx_q <= 1'b1;
    end else if (rd_en && hit_expand) begin
      page_rx_q <= 1'b0;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      partner_negotiation_capable_q <= 1'b0;
    end else begin
      partner_negotiation_capable_q <= an_partner_capable_i;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      page_received_o <= 1'b0;
    end else begin
      page_received_o <= page_rx_q;
    end
  end

  // ----------------------------------------------------------------
  // read views
  // ----------------------------------------------------------------
  logic [REG_W-1:0] advert_view;
  logic [REG_W-1:0] partner_view;
  logic [REG_W-1:0] expand_view;
  logic [REG_W-1:0] rd_view;

  always_comb begin
    advert_view                            = '0;
    advert_view[ADV_TEN_HALF]              = ten_half_q;
    advert_view[ADV_SEL_MSB:ADV_SEL_LSB]   = sel_q;
  end

  always_comb begin
    // reserved bit stays zero from the default
    partner_view                            = '0;
    partner_view[LP_MORE_PAGES]             = lp_more_q;
    partner_view[LP_ACK]                    = lp_ack_q;
    partner_view[LP_REMOTE_FLT]             = lp_rflt_q;
    partner_view[LP_ASYM_FLOW:LP_SYM_PAUSE] = lp_pause_q;
    partner_view[LP_TECH_MSB:LP_TECH_LSB]   = lp_tech_q;
    partner_view[LP_SEL_MSB:LP_SEL_LSB]     = lp_sel_q;
  end

  // bits 15:7 stay zero from the default
  always_comb begin
    expand_view                   = '0;
    expand_view[EXP_LOC_REPORTED] = 1'b1;
    expand_view[EXP_LOC_SELECT]   = loc_sel_q;
    expand_view[EXP_PD_FAULT]     = pd_fault_q;
    expand_view[EXP_PARTNER_EXTRA_PAGE_CAPABLE]   = partner_extra_page_capable_q;
    expand_view[EXP_LOCAL_NP]     = 1'b1;
    expand_view[EXP_PAGE_RX]      = page_rx_q;
    expand_view[EXP_PARTNER_NEGOTIATION_CAPABLE]   = partner_negotiation_capable_q;
  end

  // unmapped indices read zero; writes to them and to the read-only words are ignored
  always_comb begin
    unique case (idx)
      IDX_ADVERT:  rd_view = advert_view;
      IDX_PARTNER: rd_view = partner_view;
      IDX_EXPAND:  rd_view = expand_view;
      default:     rd_view = '0;
    endcase
  end

  // ----------------------------------------------------------------
  // bus answer
  // ----------------------------------------------------------------
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ack_q <= 1'b0;
    end else begin
      ack_q <= req;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wb_dat_o <= '0;
    end else if (rd_en) begin
      wb_dat_o <= {{(BUS_W-REG_W){1'b0}}, rd_view};
    end
  end

  assign wb_ack_o = ack_q;

endmodule

// ===== bench/aasr_regs_monitor.sv
// checker for the auto-negotiation register group
`timescale 1ns/1ps
module aasr_regs_monitor
  import aasr_pkg::*;
#(
  parameter int ADDR_W = 8
) (
  input wire logic              clk_i,
  input wire logic              rst_i,
  input wire logic              wb_cyc_i,
  input wire logic              wb_stb_i,
  input wire logic              wb_we_i,
  input wire logic [ADDR_W-1:0] wb_adr_i,
  input wire logic [3:0]        wb_sel_i,
  input wire logic [BUS_W-1:0]  wb_dat_i,
  input wire logic [BUS_W-1:0]  wb_dat_o,
  input wire logic              wb_ack_o,
  input wire logic              an_page_valid_i,
  input wire logic              an_next_page_valid_i,
  input wire logic              an_partner_ack_i,
  input wire logic              an_page_loc_select_i,
  input wire logic              an_parallel_fault_i,
  input wire logic              an_partner_capable_i,
  input wire logic              local_ten_half_adv_o,
  input wire logic [SEL_W-1:0]  local_selector_o,
  input wire logic              page_received_o
);
  logic             tk;
  logic [IDX_W-1:0] ix;
  logic             rd5;
  logic             rd6;
  assign tk  = wb_cyc_i & wb_stb_i & ~wb_ack_o;
  assign ix  = wb_adr_i[IDX_LSB +: IDX_W];
  assign rd5 = tk & ~wb_we_i & (ix == IDX_PARTNER);
  assign rd6 = tk & ~wb_we_i & (ix == IDX_EXPAND);
  property p_sel_rst;
    @(posedge clk_i) $fell(rst_i) |-> local_selector_o == ADV_SEL_RST;
  endproperty
  a_sel_rst: assert property (p_sel_rst) else $error("selector reset wrong");
  property p_adv_wr;
    @(posedge clk_i) disable iff (rst_i) (tk & wb_we_i & wb_sel_i[0] & (ix == IDX_ADVERT)) |=> ##1
      (local_ten_half_adv_o == $past(wb_dat_i[ADV_TEN_HALF], 2)
       && local_selector_o == $past(wb_dat_i[ADV_SEL_MSB:ADV_SEL_LSB], 2));
  endproperty
  a_adv_wr: assert property (p_adv_wr) else $error("advert write lost");
  property p_page_set;
    @(posedge clk_i) disable iff (rst_i) (an_page_valid_i | an_next_page_valid_i) |=> ##1 page_received_o;
  endproperty
  a_page_set: assert property (p_page_set) else $error("page flag not set");
  property p_page_clr;
    @(posedge clk_i) disable iff (rst_i)
      (rd6 & ~an_page_valid_i & ~an_next_page_valid_i) ##1 (~an_page_valid_i & ~an_next_page_valid_i)
      |=> !page_received_o;
  endproperty
  a_page_clr: assert property (p_page_clr) else $error("page flag not cleared");
  property p_exp_const;
    @(posedge clk_i) disable iff (rst_i) rd6 |=> wb_ack_o && wb_dat_o[31:7] == 25'h0
      && wb_dat_o[EXP_LOC_REPORTED] && wb_dat_o[EXP_LOCAL_NP];
  endproperty
  a_exp_const: assert property (p_exp_const) else $error("expansion constants wrong");
  property p_exp_lvl;
    @(posedge clk_i) disable iff (rst_i) rd6 |=> wb_dat_o[EXP_PD_FAULT] == $past(an_parallel_fault_i, 2)
      && wb_dat_o[EXP_PARTNER_NEGOTIATION_CAPABLE] == $past(an_partner_capable_i, 2);
  endproperty
  a_exp_lvl: assert property (p_exp_lvl) else $error("expansion status wrong");
  property p_exp_loc;
    @(posedge clk_i) disable iff (rst_i) rd6 |=> wb_dat_o[EXP_LOC_SELECT] == $past(an_page_loc_select_i, 2);
  endproperty
  a_exp_loc: assert property (p_exp_loc) else $error("location bit wrong");
  property p_lp_bits;
    @(posedge clk_i) disable iff (rst_i) rd5 |=> wb_dat_o[31:16] == 16'h0000
      && !wb_dat_o[LP_RESERVED] && wb_dat_o[LP_ACK] == $past(an_partner_ack_i, 2);
  endproperty
  a_lp_bits: assert property (p_lp_bits) else $error("partner word wrong");
  c_wr: cover property (@(posedge clk_i) tk & wb_we_i);
  c_rd6: cover property (@(posedge clk_i) rd6);
  c_page: cover property (@(posedge clk_i) an_page_valid_i);
endmodule
bind aasr_regs aasr_regs_monitor #(.ADDR_W(ADDR_W)) u_aasr_regs_monitor (.clk_i, .rst_i, .wb_cyc_i,
  .wb_stb_i, .wb_we_i, .wb_adr_i, .wb_sel_i, .wb_dat_i, .wb_dat_o, .wb_ack_o, .an_page_valid_i,
  .an_next_page_valid_i, .an_partner_ack_i, .an_page_loc_select_i, .an_parallel_fault_i,
  .an_partner_capable_i, .local_ten_half_adv_o, .local_selector_o, .page_received_o);

// ===== bench/aasr_link_partner.sv
// negotiation side model: received pages and partner status levels
`timescale 1ns/1ps
module aasr_link_partner
  import aasr_pkg::*;
(
  input  wire logic             clk_i,
  output logic                  page_valid_o,
  output logic      [REG_W-1:0] page_word_o,
  output logic                  next_valid_o,
  output logic      [REG_W-1:0] next_word_o,
  output logic                  ack_o,
  output logic                  loc_sel_o,
  output logic                  fault_o,
  output logic                  capable_o
);
  initial begin
    {page_valid_o, next_valid_o, ack_o, fault_o, capable_o} = 5'h00;
    loc_sel_o   = 1'b1;
    page_word_o = 16'h0000;
    next_word_o = 16'hFFFF;
  end
  task automatic send(input logic nxt, input logic [REG_W-1:0] w);
    @(posedge clk_i);
    page_valid_o <= ~nxt;
    next_valid_o <= nxt;
    page_word_o  <= w;
    next_word_o  <= w;
    @(posedge clk_i);
    page_valid_o <= 1'b0;
    next_valid_o <= 1'b0;
    // word not held once the pulse is gone
    page_word_o  <= ~w;
    next_word_o  <= ~w;
  endtask
  task automatic levels(input logic [3:0] v);
    @(posedge clk_i);
    {ack_o, loc_sel_o, fault_o, capable_o} <= v;
  endtask
endmodule

// ===== bench/tb_aasr_regs.sv
// self-checking bench for the auto-negotiation register group
`timescale 1ns/1ps
module tb_aasr_regs;
  import aasr_pkg::*;
  logic             clk_i, rst_i, wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o;
  logic [7:0]       wb_adr_i;
  logic [3:0]       wb_sel_i;
  logic [BUS_W-1:0] wb_dat_i, wb_dat_o, q;
  logic             pv, nv, pa, pl, pf, pc, ten_o, prx_o, strap;
  logic [REG_W-1:0] pw, nw;
  logic [SEL_W-1:0] sel_o;
  int               err_count = 0;
  int               n_tests = 0;
  aasr_regs #(.ADDR_W(8)) u_aasr_regs (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i),
    .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i),
    .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .strap_ten_half_i(strap),
    .an_page_valid_i(pv), .an_page_word_i(pw), .an_next_page_valid_i(nv), .an_next_page_word_i(nw),
    .an_partner_ack_i(pa), .an_page_loc_select_i(pl), .an_parallel_fault_i(pf),
    .an_partner_capable_i(pc), .local_ten_half_adv_o(ten_o), .local_selector_o(sel_o),
    .page_received_o(prx_o));
  aasr_link_partner u_aasr_link_partner (.clk_i(clk_i), .page_valid_o(pv), .page_word_o(pw),
    .next_valid_o(nv), .next_word_o(nw), .ack_o(pa), .loc_sel_o(pl), .fault_o(pf), .capable_o(pc));
  initial begin
    clk_i = 1'b0;
    forever #5 clk_i = ~clk_i;
  end
  task automatic close_out;
    $display("checks %0d mismatches %0d", n_tests, err_count);
    if (err_count == 0 && n_tests > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask
  task automatic chk(input string nm, input logic [BUS_W-1:0] s, input logic [BUS_W-1:0] e);
    n_tests++;
    if (s !== e) begin
      err_count++;
      $display("ERROR %s expected %h seen %h", nm, e, s);
    end
  endtask
  // no ack within the bound counts as a mismatch
  task automatic wb(input logic we, input logic [7:0] a, input logic [BUS_W-1:0] d, input logic [3:0] s);
    int n;
    n = 0;
    @(posedge clk_i);
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i  <= we;
    wb_adr_i <= a;
    wb_dat_i <= d;
    wb_sel_i <= s;
    do begin
      @(posedge clk_i);
      n++;
    end while (wb_ack_o !== 1'b1 && n < 20);
    chk("wb_ack", {31'h0, wb_ack_o}, 32'h1);
    q = wb_dat_o;
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
  endtask
  task automatic rc(input logic [7:0] a, input logic [BUS_W-1:0] e, input string nm);
    wb(1'b0, a, 32'h0, 4'hF);
    chk(nm, q, e);
  endtask
  initial begin
    #50us;
    chk("watchdog", 32'h0, 32'h1);
    close_out;
  end
  initial begin
    {wb_cyc_i, wb_stb_i, wb_we_i} = 3'h0;
    {wb_adr_i, wb_sel_i, wb_dat_i} = 44'h0;
    rst_i = 1'b1;
    strap = 1'b1;
    repeat (16) @(posedge clk_i);
    rst_i <= 1'b0;
    @(posedge clk_i);
    chk("sel_out", {27'h0, sel_o}, 32'h01);
    rc(8'h10, 32'h21, "advert");
    rc(8'h14, 32'h0, "partner");
    rc(8'h18, 32'h64, "expand");
    wb(1'b1, 8'h10, 32'hFFFF_FFDE, 4'hF);
    rc(8'h10, 32'h1E, "advert_wr");
    chk("adv_out", {26'h0, ten_o, sel_o}, 32'h1E);
    wb(1'b1, 8'h10, 32'h0, 4'hE);
    rc(8'h10, 32'h1E, "advert_lane");
    wb(1'b1, 8'h14, 32'hFFFF_EFFF, 4'hF);
    wb(1'b1, 8'h18, 32'hFFFF_FFFF, 4'hF);
    wb(1'b1, 8'h3C, 32'hFFFF_FFFF, 4'hF);
    rc(8'h14, 32'h0, "partner_ro");
    rc(8'h18, 32'h64, "expand_ro");
    rc(8'h3C, 32'h0, "unmapped");
    u_aasr_link_partner.levels(4'b1101);
    // partner sends a base page after the advert change
    u_aasr_link_partner.send(1'b0, 16'hFFFF);
    @(posedge clk_i);
    #1;
    chk("page_out", {31'h0, prx_o}, 32'h1);
    rc(8'h14, 32'hEFFF, "base");
    rc(8'h18, 32'h6F, "exp_page");
    rc(8'h18, 32'h6D, "exp_cor");
    @(posedge clk_i);
    #1;
    chk("page_out", {31'h0, prx_o}, 32'h0);
    u_aasr_link_partner.levels(4'b1110);
    rc(8'h18, 32'h7C, "exp_fault");
    u_aasr_link_partner.send(1'b1, 16'h1234);
    rc(8'h14, 32'hEFFF, "np_kept");
    rc(8'h18, 32'h7E, "exp_np");
    u_aasr_link_partner.levels(4'b0000);
    u_aasr_link_partner.send(1'b1, 16'h0021);
    rc(8'h14, 32'h0021, "np_load");
    rc(8'h18, 32'h4E, "exp_loc0");
    u_aasr_link_partner.send(1'b0, 16'h5A5A);
    rc(8'h14, 32'h0A5A, "base2");
    rc(8'h18, 32'h46, "exp_np0");
    // second reset with the strap low
    strap <= 1'b0;
    rst_i <= 1'b1;
    repeat (8) @(posedge clk_i);
    rst_i <= 1'b0;
    @(posedge clk_i);
    rc(8'h10, 32'h01, "advert_rst");
    rc(8'h14, 32'h0, "partner_rst");
    rc(8'h18, 32'h44, "expand_rst");
    chk("adv_out_rst", {26'h0, ten_o, sel_o}, 32'h01);
    close_out;
  end
endmodule
